// ---- pkg/lt_status_pkg.sv ----
// Package: register map, field layout and carriers for the training status
package lt_status_pkg;

  // Register indices (printed offsets are word indices, not multiples of 4)
  localparam logic [11:0] IDX_STATUS = 12'h4d2;
  localparam logic [11:0] IDX_WINDOW = 12'h4d3;
  localparam logic [13:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [13:0] ADDR_WINDOW = {IDX_WINDOW, 2'b00};

  // Status bit positions
  localparam int unsigned ST_RX_TRAINED   = 0;
  localparam int unsigned ST_FRAME_LOCK   = 1;
  localparam int unsigned ST_STARTUP      = 2;
  localparam int unsigned ST_FAILURE      = 3;
  localparam int unsigned ST_BER_ERR      = 4;
  localparam int unsigned ST_LOCK_ERR     = 5;
  localparam int unsigned ST_RECEIVE_EQUALIZATION_PHASE_LOSS    = 6;
  localparam int unsigned ST_FINE_ERR     = 7;
  localparam int unsigned ST_WIDTH        = 8;

  // Window field positions
  localparam int unsigned WIN_FRAMES_LSB   = 0;
  localparam int unsigned WIN_K_FRAMES_LSB = 10;
  localparam int unsigned WIN_M_FRAMES_LSB = 20;
  localparam int unsigned WIN_FIELD_W      = 10;

  // Window field reset values per build
  localparam logic [9:0] RST_FRAMES_SIM   = 10'h003;
  localparam logic [9:0] RST_FRAMES_HW    = 10'h000;
  localparam logic [9:0] RST_K_FRAMES_SIM = 10'h000;
  localparam logic [9:0] RST_K_FRAMES_HW  = 10'h00f;
  localparam logic [9:0] RST_M_FRAMES     = 10'h000;

  // Training flags from the training state machine
  typedef struct packed {
    logic fine_err;
    logic receive_equalization_phase_loss;
    logic lock_err;
    logic ber_err;
    logic failure;
    logic startup;
    logic frame_lock;
    logic rx_trained;
  } train_flags_t;

  // Measurement window as used by the stepping logic
  typedef struct packed {
    logic [9:0] m_frames;
    logic [9:0] k_frames;
    logic [9:0] frames;
  } ber_window_t;

endpackage

// ---- design/lt_status_regs.sv ----
// Training status flags and bit-error window register behind an APB slave
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps

// Contract
// - bit 0 shows receiver trained
// - bit 1 shows frame delineation lock
// - bit 2 shows start-up protocol running
// - bit 3 shows training failure
// - bit 4 shows excessive bit errors
// - bit 5 shows frame lock lost
// - lock loss with initial taps unrecoverable
// - bit 6 shows equalization frame lock loss
// - bit 7 shows fine tuning failure
// - bits 9:0 frames, used when thousands zero
// - bits 19:10 thousands of frames
// - bits 29:20 millions of frames
// - thousands field resets 0xF hardware, 0 sim
// - frames field resets 3 sim, 0 hardware
// - failure status set on wait timer expiry
module lt_status_regs #(
  parameter bit SIM_BUILD = 1'b0
) (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [13:0]                paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Training logic side
  input  wire lt_status_pkg::train_flags_t flags_in,
  input  wire logic                       max_wait_done,
  input  wire logic                       taps_at_init,
  output lt_status_pkg::ber_window_t      window,
  output logic                            window_use_frames,
  output logic                            lock_unrecoverable,
  output lt_status_pkg::train_flags_t     status
);

  // Window field reset values chosen by build type
  localparam logic [9:0] FR_RST =
    SIM_BUILD ? lt_status_pkg::RST_FRAMES_SIM : lt_status_pkg::RST_FRAMES_HW;
  localparam logic [9:0] KF_RST =
    SIM_BUILD ? lt_status_pkg::RST_K_FRAMES_SIM
              : lt_status_pkg::RST_K_FRAMES_HW;

  // Registered state and next values
  lt_status_pkg::train_flags_t status_r, status_nxt;
  lt_status_pkg::ber_window_t  window_r, window_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        use_fr_r, use_fr_nxt;
  logic        unrec_r, unrec_nxt;

  // Byte-lane merge for a window write
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Setup phase of an APB transfer: answer comes in the access phase
  logic setup;
  logic access;
  logic hit_st;
  logic hit_win;
  logic [31:0] win_word;
  logic [31:0] win_merged;
  assign setup      = psel && !penable;
  // Access edge: the only edge at which a write may land
  assign access     = psel && penable && pready_r;
  assign hit_st     = (paddr == lt_status_pkg::ADDR_STATUS);
  assign hit_win    = (paddr == lt_status_pkg::ADDR_WINDOW);
  assign win_word   = {2'b00, window_r};
  assign win_merged = merge_bytes(win_word, pwdata, pstrb);

  // Next-state logic for flags, window and bus answer
  always_comb begin
    status_nxt  = flags_in;
    window_nxt  = window_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    status_nxt.failure = flags_in.failure || max_wait_done;
    if (setup) begin
      // One wait-free access phase: ready in the cycle after setup
      pready_nxt = 1'b1;
      if (pwrite) begin
        prdata_nxt = 32'h0000_0000;
        if (!hit_win && !hit_st) begin
          pslverr_nxt = 1'b1;
        end
        // writes to the status word change nothing
      end else if (hit_st) begin
        prdata_nxt = {24'h00_0000, status_r};
      end else if (hit_win) begin
        prdata_nxt = win_word;
      end else begin
        // Unmapped address reads zero with an error
        prdata_nxt  = 32'h0000_0000;
        pslverr_nxt = 1'b1;
      end
    end
    // Window write lands when the master samples ready high
    if (access && pwrite && hit_win) begin
      window_nxt = win_merged[29:0];
    end
    // frames count used only when thousands is zero
    use_fr_nxt = (window_nxt.k_frames == 10'h000);
    // lock lost while taps are still initial values
    unrec_nxt = status_nxt.lock_err && taps_at_init;
  end

  // Registers; reset values are constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r  <= '0;
      window_r  <= {lt_status_pkg::RST_M_FRAMES, KF_RST, FR_RST};
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      use_fr_r  <= (KF_RST == 10'h000);
      unrec_r   <= 1'b0;
    end else begin
      status_r  <= status_nxt;
      window_r  <= window_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      use_fr_r  <= use_fr_nxt;
      unrec_r   <= unrec_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign status             = status_r;
  assign window             = window_r;
  assign window_use_frames  = use_fr_r;
  assign lock_unrecoverable = unrec_r;

  // Checks
  a_rx_trained: assert property (@(posedge pclk) disable iff (!presetn)
    status_r.rx_trained == $past(flags_in.rx_trained))
    else $error("rx trained flag wrong");
  a_frame_lock: assert property (@(posedge pclk) disable iff (!presetn)
    status_r.frame_lock == $past(flags_in.frame_lock))
    else $error("frame lock flag wrong");
  a_startup_bit: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(flags_in.startup) |=> !status_r.startup)
    else $error("startup flag not cleared");
  a_fail_timer: assert property (@(posedge pclk) disable iff (!presetn)
    max_wait_done |=> status_r.failure)
    else $error("failure not set on timer expiry");
  a_fail_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !flags_in.failure && !max_wait_done |=> !status_r.failure)
    else $error("failure flag set without cause");
  a_ber_err: assert property (@(posedge pclk) disable iff (!presetn)
    flags_in.ber_err |=> status_r.ber_err)
    else $error("bit error flag missing");
  a_lock_err: assert property (@(posedge pclk) disable iff (!presetn)
    status_r.lock_err == $past(flags_in.lock_err))
    else $error("lock error flag wrong");
  a_unrec_lock: assert property (@(posedge pclk) disable iff (!presetn)
    flags_in.lock_err && taps_at_init |=> lock_unrecoverable)
    else $error("unrecoverable lock not flagged");
  a_receive_equalization_phase_loss: assert property (@(posedge pclk) disable iff (!presetn)
    status_r.receive_equalization_phase_loss == $past(flags_in.receive_equalization_phase_loss))
    else $error("equalization loss flag wrong");
  a_fine_err: assert property (@(posedge pclk) disable iff (!presetn)
    status_r.fine_err == $past(flags_in.fine_err))
    else $error("fine tuning flag wrong");
  a_use_frames: assert property (@(posedge pclk) disable iff (!presetn)
    window_use_frames == (window_r.k_frames == 10'h000))
    else $error("frames select wrong");
  a_win_write: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && hit_win && (pstrb == 4'hf)
      |=> window_r == $past(pwdata[29:0]))
    else $error("window write lost");
  a_read_ready: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  a_status_ro: assert property (@(posedge pclk) disable iff (!presetn)
    setup && pwrite && hit_st |=> !pslverr && $stable(window_r))
    else $error("status write had an effect");

endmodule

// ---- tb/lt_partner_model.sv ----
// Far-side model: training engine flags as driven from the link
`timescale 1ns/1ps
module lt_partner_model (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // Requested state {taps, wait, flags}
  input  wire logic [9:0]                  want,
  // Flags toward the status block
  output lt_status_pkg::train_flags_t      flags_out,
  output logic                             wait_done,
  output logic                             taps_init
);
  // One flop stage, as the real engine updates on the clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_out <= '0;
      wait_done <= 1'b0;
      taps_init <= 1'b0;
    end else begin
      flags_out <= want[7:0];
      wait_done <= want[8];
      taps_init <= want[9];
    end
  end
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the status and window registers
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb;
  logic                        pclk, presetn, psel, penable, pwrite;
  logic [13:0]                 paddr;
  logic [31:0]                 pwdata, prdata, seed, d;
  logic [3:0]                  pstrb;
  logic                        pready, pslverr, use_fr, unrec, wd, ti;
  logic [9:0]                  want;
  logic [7:0]                  x;
  lt_status_pkg::train_flags_t flags, status;
  lt_status_pkg::ber_window_t  window;
  logic [33:0]                 expq[$]; // Notes {read, err, data}
  logic [33:0]                 e;
  int                          fails, checked;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  lt_partner_model i_lt_partner_model (.pclk(pclk), .presetn(presetn),
    .want(want), .flags_out(flags), .wait_done(wd), .taps_init(ti));
  lt_status_regs #(.SIM_BUILD(1'b1)) i_lt_status_regs (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flags_in(flags),
    .max_wait_done(wd), .taps_at_init(ti), .window(window),
    .window_use_frames(use_fr), .lock_unrecoverable(unrec),
    .status(status));
  task automatic print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Monitor: each completed transfer consumes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      if (e[33]) `CHK(prdata, e[31:0])
      `CHK(pslverr, e[32])
    end
  end
  // APB master: setup, access, hold until pready
  task automatic apb(input logic w, input logic [13:0] a,
                     input logic [31:0] wd_, input logic [33:0] ex);
    int n;
    expq.push_back(ex);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd_;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Flags need the partner stage plus the status stage
  task automatic drive(input logic [9:0] v);
    @(posedge pclk);
    want <= v;
    repeat (3) @(posedge pclk);
    #1;
    x = v[7:0] | {4'h0, v[8], 3'h0};
    `CHK(status, x)
    `CHK(unrec, v[5] & v[9])
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, want} = '0;
    pstrb = 4'hf;
    presetn = 1'b0;
    seed = 32'd69222;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Simulation build resets to three single frames
    `CHK(window, 30'h3)
    apb(1'b0, lt_status_pkg::ADDR_WINDOW, '0, {2'b10, 32'h3});
    $display("reset test done");
    drive(10'h100);
    drive(10'h220);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      drive(seed[9:0]);
      // Status writes are dropped, the live flags read back
      apb(1'b1, lt_status_pkg::ADDR_STATUS, seed, '0);
      apb(1'b0, lt_status_pkg::ADDR_STATUS, '0, {2'b10, 24'h0, x});
    end
    $display("status test done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      d = seed & ((i == 1) ? 32'h3ff003ff : 32'h3fffffff);
      apb(1'b1, lt_status_pkg::ADDR_WINDOW, d, '0);
      apb(1'b0, lt_status_pkg::ADDR_WINDOW, '0, {2'b10, d});
      `CHK(window, d[29:0])
      `CHK(use_fr, d[19:10] == 10'h000)
    end
    $display("window test done");
    // Unmapped word answers with an error and zero data
    apb(1'b0, 14'h0010, '0, {2'b11, 32'h0});
    $display("unmapped test done");
    repeat (2) @(posedge pclk);
    print_verdict();
  end
endmodule
